// *** core/stc_pkg.sv ***
// Purpose: shared constants and types of the self-test and reset control
// Assumes: 200 MHz system clock, 8-bit register port with 16-bit address
// Notes: times are kept in microseconds and turned into cycle counts here
package stc_pkg;
  localparam logic [15:0] STC_ADDR_SCRATCH = 16'hA014;
  localparam logic [15:0] STC_ADDR_CMD = 16'hA016;
  localparam logic [7:0] STC_SCRATCH_RST = 8'h00;
  localparam logic [3:0] STC_MODE_RST = 4'h0;
  localparam logic [7:0] STC_RDATA_RST = 8'h00;
  // Field positions of the command/status register
  localparam int STC_MODE_LSB = 4;
  localparam int STC_BUSY_BIT = 3;
  localparam int STC_FAIL_BIT = 1;
  localparam int STC_FINISH_BIT = 0;
  localparam logic [3:0] STC_CMD_CLEAR = 4'h0;
  localparam logic [3:0] STC_CMD_RUN = 4'h5;
  localparam logic [3:0] STC_CMD_RUN_RESET = 4'hA;
  localparam logic [3:0] STC_MODE_NORMAL_A = 4'h0;
  localparam logic [3:0] STC_MODE_NORMAL_B = 4'h8;
  localparam logic [3:0] STC_MODE_MEM = 4'h1;
  localparam logic [3:0] STC_MODE_LOGIC = 4'h4;
  localparam logic [3:0] STC_MODE_MEM_PINS = 4'h9;
  // Synchroniser order: {lvd, reset pin, clock present, slow osc}
  localparam logic [3:0] STC_SYNC_RST = 4'h6;
  localparam int STC_CLK_MHZ = 200;
  localparam int STC_PIN_FILTER_US = 4000;
  localparam int STC_STRETCH_US = 4000;
  localparam int STC_PIN_FILTER_CYC = STC_PIN_FILTER_US * STC_CLK_MHZ;
  localparam int STC_STRETCH_CYC = STC_STRETCH_US * STC_CLK_MHZ;
  localparam logic [2:0] STC_CLKMON_SLOW_CYC = 3'h4;
  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] cmd;
  } stc_cmd_wr_t;
  typedef struct packed {
    logic [3:0] mode;
    logic busy;
    logic rsvd;
    logic fail;
    logic finish;
  } stc_status_t;
  typedef enum logic [0:0] {STC_IDLE, STC_RUN} stc_state_t;
endpackage

// *** core/stc_self_test_reset.sv ***
// Purpose: self-test command/status, scratch register, clock monitor, reset control
// Assumes: one clock; pin, slow oscillator and detectors arrive asynchronously
// Notes: the self-test engine itself sits outside and reports done and error
`timescale 1ns/10ps
// Behaviour
// R1 - Failure flag sets on test error, cleared when a new test starts.
// R2 - Command 0101 starts a test in the selected mode.
// R3 - Command 1010 runs a test then issues a software reset.
// R4 - Command 0000 clears failure and completion flags.
// R5 - Other command codes do nothing, or abort a running test.
// R6 - Processor is stalled from accepted command until the test ends.
// R7 - Processor and memory contents need not survive a test.
// R8 - Software should reset or reinitialise after any self-test.
// R9 - Mode, completion and failure survive software resets only.
// R10 - Scratch register is read/write, cleared only by power-on reset.
// R11 - System clock absent four slow cycles in normal mode forces hardware reset.
// R12 - Command, watchdog and fetch ECC resets are software class.
// R13 - Power-on, low voltage, clock monitor and pin resets are hardware class.
// R14 - Software reset clears a subset, hardware reset clears all but the scratch register.
// R15 - Reset pin lows shorter than 4 ms are ignored.
// R16 - Hardware reset is held 4 ms longer after its cause ends.
// R17 - Internal hardware reset drives the reset pin low.
// R18 - Mode field selects normal, memory, logic or memory-with-pins test.
// R19 - Busy bit is high for the whole run, low after end or abort.
// R20 - Completion flag sets at run end, cleared when a new test starts.
module stc_self_test_reset #(
  parameter int unsigned PIN_FILTER_CYC = stc_pkg::STC_PIN_FILTER_CYC,
  parameter int unsigned STRETCH_CYC = stc_pkg::STC_STRETCH_CYC
) (
  input wire logic I_CLK_SYS, // System clock
  input wire logic I_RESET, // Power-on reset, async high
  input wire logic [15:0] I_ADDR, // Register address
  input wire logic [7:0] I_WDATA, // Write data
  input wire logic I_WR, // Write strobe
  input wire logic I_RD, // Read strobe
  output logic [7:0] O_RDATA, // Read data, cycle after strobe
  input wire logic I_BIST_DONE, // Engine finished
  input wire logic I_BIST_ERROR, // Engine saw an error
  output logic O_BIST_MEM, // Run memory test
  output logic O_BIST_LOGIC, // Run register logic test
  output logic O_BIST_PIN_MON, // Memory test results to pins
  output logic O_BIST_ABORT, // Abort pulse to engine
  output logic [3:0] O_BIST_MODE, // Selected mode
  output logic O_CPU_STALL, // Processor pause
  input wire logic I_SLOW_OSC, // Slow oscillator, async
  input wire logic I_SYSTEM_CLOCK_PRESENT, // Clock detector level, async
  input wire logic I_NORMAL_MODE, // Power mode is normal running
  input wire logic I_LVD, // Main supply low voltage, async
  input wire logic I_WDT_RESET, // Watchdog reset pulse
  input wire logic I_ECC_RESET, // Fetch ECC reset pulse
  input wire logic I_EXT_RESET_N_IN, // Reset pin level
  output logic O_EXT_RESET_N_OUT, // Reset pin drive value
  output logic O_EXT_RESET_N_OE, // Reset pin drive enable
  output logic O_SW_RESET, // Software-class reset pulse
  output logic O_HW_RESET // Hardware-class reset level
);
  localparam int SN = 4;
  localparam logic [31:0] FILT_N = 32'(PIN_FILTER_CYC);
  localparam logic [31:0] STR_N = 32'(STRETCH_CYC);

  logic [SN-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
  logic slow_prev_reg;
  logic [2:0] mon_cnt_reg;
  logic [31:0] pin_cnt_reg, str_cnt_reg;
  logic drive_reg, ext_wait_reg, hw_out_reg, sw_reset_reg;
  stc_pkg::stc_state_t state_reg;
  logic rst_after_reg, abort_reg;
  logic [3:0] mode_reg;
  logic fail_reg, finish_reg;
  logic [7:0] scratch_reg, rdata_reg;

  // Bus decode
  wire logic sel_cmd = I_ADDR == stc_pkg::STC_ADDR_CMD;
  wire logic sel_scr = I_ADDR == stc_pkg::STC_ADDR_SCRATCH;
  wire logic wr_cmd = I_WR & sel_cmd;
  wire logic wr_scr = I_WR & sel_scr;
  wire stc_pkg::stc_cmd_wr_t cmd_wr = stc_pkg::stc_cmd_wr_t'(I_WDATA);
  wire logic busy = state_reg == stc_pkg::STC_RUN;
  wire logic cmd_start = cmd_wr.cmd == stc_pkg::STC_CMD_RUN ||
                         cmd_wr.cmd == stc_pkg::STC_CMD_RUN_RESET;
  wire logic cmd_clear = cmd_wr.cmd == stc_pkg::STC_CMD_CLEAR;
  wire logic accept = wr_cmd & cmd_start & ~busy; // [R2] [R3]
  wire logic clear = wr_cmd & cmd_clear; // [R4]
  wire logic abort = wr_cmd & ~cmd_start & ~cmd_clear & busy; // [R5]

  // Mode decode; a mode with no test finishes at once so the stall ends
  wire logic m_mem = mode_reg == stc_pkg::STC_MODE_MEM; // [R18]
  wire logic m_pins = mode_reg == stc_pkg::STC_MODE_MEM_PINS; // [R18]
  wire logic m_logic = mode_reg == stc_pkg::STC_MODE_LOGIC; // [R18]
  wire logic no_test = ~(m_mem | m_pins | m_logic);
  wire logic done_ev = busy & (I_BIST_DONE | no_test);
  wire logic err_ev = busy & I_BIST_ERROR & ~no_test;
  wire logic cmd_rst = done_ev & rst_after_reg; // [R3]

  // Software-class sources; hw reset forces run control, mode and flags back
  wire logic sw_next = cmd_rst | I_WDT_RESET | I_ECC_RESET; // [R12]
  wire logic hw_rst = hw_out_reg;
  wire logic run_kill = hw_rst | sw_reset_reg; // [R14]

  stc_pkg::stc_state_t state_next;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      stc_pkg::STC_IDLE: if (accept) state_next = stc_pkg::STC_RUN; // [R2]
      stc_pkg::STC_RUN: if (done_ev | abort) state_next = stc_pkg::STC_IDLE; // [R19]
    endcase
    if (run_kill) state_next = stc_pkg::STC_IDLE;
  end

  // A test event in the same cycle as a clear keeps its flag
  wire logic flag_clr = accept | clear;
  wire logic fail_next = err_ev | (fail_reg & ~flag_clr); // [R1] [R4]
  wire logic finish_next = done_ev | (finish_reg & ~flag_clr); // [R20] [R4]
  wire logic [3:0] mode_next = (wr_cmd & ~busy) ? cmd_wr.mode : mode_reg;
  wire logic rst_after_next = accept ? (cmd_wr.cmd == stc_pkg::STC_CMD_RUN_RESET) :
                              (busy ? rst_after_reg : 1'b0);

  wire stc_pkg::stc_status_t status = '{mode: mode_reg, busy: busy, rsvd: 1'b0,
                                        fail: fail_reg, finish: finish_reg};
  wire logic [7:0] rdata_next = ~I_RD ? stc_pkg::STC_RDATA_RST :
                                sel_cmd ? 8'(status) :
                                sel_scr ? scratch_reg : stc_pkg::STC_RDATA_RST;

  // Input synchronisers and glitch-free level
  wire logic [SN-1:0] raw_in = {I_LVD, I_EXT_RESET_N_IN, I_SYSTEM_CLOCK_PRESENT, I_SLOW_OSC};
  wire logic [SN-1:0] filt_next = (sync2_reg & sync3_reg) |
                                  (filt_reg & (sync2_reg | sync3_reg));
  wire logic slow_lvl = filt_reg[0];
  wire logic clk_ok = filt_reg[1];
  wire logic pin_high = filt_reg[2];
  wire logic low_voltage_detect = filt_reg[3];
  wire logic slow_rise = slow_lvl & ~slow_prev_reg;

  // Clock monitor counts slow edges while the system clock is missing
  wire logic mon_fail = mon_cnt_reg == stc_pkg::STC_CLKMON_SLOW_CYC; // [R11]
  wire logic [2:0] mon_cnt_next = (~I_NORMAL_MODE | clk_ok) ? 3'h0 :
                                  (slow_rise & ~mon_fail) ? 3'(mon_cnt_reg + 3'h1) :
                                  mon_cnt_reg; // [R11]

  // Pin filter is held at zero while we drive the pin, or our own low would retrigger
  wire logic pin_rst = pin_cnt_reg == FILT_N; // [R15]
  wire logic [31:0] pin_cnt_next = (pin_high | drive_reg | ext_wait_reg) ? 32'h0 :
                                   pin_rst ? pin_cnt_reg :
                                   32'(pin_cnt_reg + 32'h1); // [R15]

  wire logic hw_cause = low_voltage_detect | mon_fail | pin_rst; // [R13]
  wire logic [31:0] str_cnt_next = hw_cause ? STR_N :
                                   (str_cnt_reg != 32'h0) ? 32'(str_cnt_reg - 32'h1) :
                                   32'h0; // [R16]
  wire logic stretching = hw_cause | (str_cnt_reg != 32'h0); // [R16]
  // After release the pin RC keeps reset until the pin reads high
  wire logic ext_wait_next = drive_reg | (ext_wait_reg & ~pin_high); // [R17]
  wire logic hw_out_next = stretching | drive_reg | ext_wait_reg; // [R13]

  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      sync1_reg <= stc_pkg::STC_SYNC_RST;
      sync2_reg <= stc_pkg::STC_SYNC_RST;
      sync3_reg <= stc_pkg::STC_SYNC_RST;
      filt_reg <= stc_pkg::STC_SYNC_RST;
      slow_prev_reg <= 1'b0;
      mon_cnt_reg <= 3'h0;
      pin_cnt_reg <= 32'h0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
      slow_prev_reg <= slow_lvl;
      mon_cnt_reg <= mon_cnt_next;
      pin_cnt_reg <= pin_cnt_next;
    end
  end

  // Power-on itself is a hardware cause, so stretch starts loaded
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      str_cnt_reg <= STR_N;
      drive_reg <= 1'b1;
      ext_wait_reg <= 1'b0;
      hw_out_reg <= 1'b1;
      sw_reset_reg <= 1'b0;
    end else begin
      str_cnt_reg <= str_cnt_next;
      drive_reg <= stretching; // [R17]
      ext_wait_reg <= ext_wait_next;
      hw_out_reg <= hw_out_next;
      sw_reset_reg <= sw_next & ~hw_rst; // [R12]
    end
  end

  // Run control is cleared by either reset class
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      state_reg <= stc_pkg::STC_IDLE;
      rst_after_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rst_after_reg <= rst_after_next & ~run_kill; // [R14]
      abort_reg <= busy & (abort | run_kill); // [R5]
    end
  end

  // Flags and mode ignore software resets
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      mode_reg <= stc_pkg::STC_MODE_RST;
      fail_reg <= 1'b0;
      finish_reg <= 1'b0;
    end else if (hw_rst) begin
      mode_reg <= stc_pkg::STC_MODE_RST; // [R9] [R14]
      fail_reg <= 1'b0;
      finish_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next; // [R9]
      fail_reg <= fail_next;
      finish_reg <= finish_next;
    end
  end

  // Scratch survives every reset but power-on
  always_ff @(posedge I_CLK_SYS or posedge I_RESET) begin
    if (I_RESET) begin
      scratch_reg <= stc_pkg::STC_SCRATCH_RST; // [R10]
      rdata_reg <= stc_pkg::STC_RDATA_RST;
    end else begin
      if (wr_scr) scratch_reg <= I_WDATA; // [R10]
      rdata_reg <= rdata_next;
    end
  end

  assign O_RDATA = rdata_reg;
  // Memory and processor state are left to software after a run
  assign O_CPU_STALL = busy; // [R6] [R7]
  assign O_BIST_MEM = busy & (m_mem | m_pins);
  assign O_BIST_LOGIC = busy & m_logic;
  assign O_BIST_PIN_MON = busy & m_pins;
  assign O_BIST_ABORT = abort_reg;
  assign O_BIST_MODE = mode_reg;
  assign O_EXT_RESET_N_OUT = 1'b0;
  assign O_EXT_RESET_N_OE = drive_reg; // [R17]
  assign O_SW_RESET = sw_reset_reg;
  assign O_HW_RESET = hw_out_reg;

  localparam int MON_WAIT = 3;

  sequence seq_start;
    accept;
  endsequence
  sequence seq_run_done;
    busy && done_ev;
  endsequence

  a_fail_new_cmd: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R1]
    seq_start |=> !fail_reg) else $error("fail flag kept after new command");
  a_fail_set: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R1]
    err_ev && !hw_rst |=> fail_reg) else $error("test error not flagged");
  a_start_run: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R2]
    (seq_start and !run_kill) |=> busy) else $error("start did not begin a run");
  a_auto_reset: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R3]
    (seq_run_done and (rst_after_reg && !hw_rst)) |=> O_SW_RESET)
    else $error("no software reset after run");
  a_clear_flags: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R4]
    clear && !busy |=> !fail_reg && !finish_reg) else $error("clear left flags set");
  a_abort_run: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R5]
    abort |=> !busy ##0 O_BIST_ABORT) else $error("abort did not stop run");
  a_stall_run: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R6]
    (seq_start and !run_kill) |=> O_CPU_STALL throughout (busy [*1]))
    else $error("processor not stalled during run");
  a_flags_sw: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R9]
    O_SW_RESET && !hw_rst && !wr_cmd && !busy |=> $stable(mode_reg) && $stable(finish_reg))
    else $error("software reset changed kept fields");
  a_scratch_rw: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R10]
    wr_scr ##1 (I_RD && sel_scr && !I_WR) |=> O_RDATA == $past(I_WDATA, 2))
    else $error("scratch read mismatch");
  a_clk_mon: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R11]
    mon_fail |-> ##[1:MON_WAIT] O_HW_RESET) else $error("clock loss gave no reset");
  a_sw_class: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R12]
    I_WDT_RESET && !hw_rst |=> O_SW_RESET) else $error("watchdog reset not software class");
  a_pin_glitch: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R15]
    pin_high |=> !pin_rst) else $error("pin reset without long low");
  a_stretch: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R16]
    $fell(hw_cause) |-> O_HW_RESET [*8]) else $error("hardware reset not stretched");
  a_pin_drive: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R17]
    stretching |=> O_EXT_RESET_N_OE && !O_EXT_RESET_N_OUT) else $error("pin not driven low");
  a_busy_end: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R19]
    seq_run_done |=> !busy) else $error("busy stayed after run end");
  a_finish_set: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R20]
    (seq_run_done and !hw_rst) |=> finish_reg) else $error("completion not flagged");

  // Holding, clearing and the reset path
  sequence seq_abort;
    abort;
  endsequence
  sequence seq_hw_hold;
    O_HW_RESET;
  endsequence

  a_fail_keep: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R1]
    fail_reg && !flag_clr && !hw_rst |=> fail_reg)
    else $error("fail flag lost without clear");
  a_finish_keep: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R20]
    finish_reg && !flag_clr && !hw_rst |=> finish_reg)
    else $error("completion flag lost without clear");
  a_no_test_end: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R19]
    busy && no_test |=> !busy)
    else $error("run without a test did not end");
  a_status_read: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R19]
    I_RD && sel_cmd |=> O_RDATA[stc_pkg::STC_BUSY_BIT] == $past(busy))
    else $error("busy bit read wrong");
  a_mode_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R18]
    wr_cmd && busy && !hw_rst |=> $stable(mode_reg))
    else $error("mode changed during a run");
  a_mode_write: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R18]
    wr_cmd && !busy && !hw_rst |=> O_BIST_MODE == $past(I_WDATA[7:4]))
    else $error("mode write not taken");
  a_abort_pulse: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R5]
    seq_abort ##1 O_BIST_ABORT |=> !O_BIST_ABORT)
    else $error("abort pulse too long");
  a_sw_ecc: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R12]
    I_ECC_RESET && !hw_rst |=> O_SW_RESET)
    else $error("fetch error reset not software class");
  a_sw_blocked: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R14]
    seq_hw_hold |=> !O_SW_RESET)
    else $error("software reset during hardware reset");
  a_hw_clears: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R14]
    seq_hw_hold |=> !busy && mode_reg == stc_pkg::STC_MODE_RST &&
    !fail_reg && !finish_reg)
    else $error("hardware reset left state");
  a_scratch_hw: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R10]
    (seq_hw_hold and !wr_scr) |=> $stable(scratch_reg))
    else $error("scratch lost in hardware reset");
  a_rdata_idle: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R10]
    !I_RD |=> O_RDATA == stc_pkg::STC_RDATA_RST)
    else $error("read data without read strobe");
  a_mon_idle: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R11]
    !I_NORMAL_MODE |=> mon_cnt_reg == 3'h0)
    else $error("clock monitor counted outside normal mode");
  a_pin_frozen: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R15]
    drive_reg |=> pin_cnt_reg == 32'h0)
    else $error("pin filter ran while pin driven");
  a_pin_release: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R17]
    !stretching |=> !O_EXT_RESET_N_OE)
    else $error("pin held after stretch");
  a_wait_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET) // [R17]
    drive_reg |=> O_HW_RESET)
    else $error("reset released while pin driven");
endmodule // stc_self_test_reset

// *** tb/stc_far_model.sv ***
// Purpose: far-side model: self-test engine answers and the reset pin wire
// Assumes: engine runs while a memory or logic test is requested
// Notes: pin is open drain with a pull-up, so a released pin reads high
`timescale 1ns/10ps
module stc_far_model (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic run_req, // Engine asked to run
  input wire logic [7:0] delay, // Cycles until the engine finishes
  input wire logic inject_err, // Report an error with done
  input wire logic pin_pull_low, // Outside party holds the pin low
  input wire logic pin_oe, // Device drives the pin
  input wire logic pin_out, // Device drive value
  output logic done, // Engine done pulse
  output logic error, // Engine error pulse
  output logic pin_level // Resolved pin level
);
  logic run_d;
  logic [7:0] cnt;
  logic fire;
  assign fire = run_req && run_d && (cnt == 8'h01);
  assign pin_level = !(pin_pull_low || (pin_oe && !pin_out));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_d <= 1'b0;
      cnt <= 8'h00;
      done <= 1'b0;
      error <= 1'b0;
    end else begin
      run_d <= run_req;
      // A dropped request stops the count, so an abort never yields a late done
      if (run_req && !run_d) begin
        cnt <= delay;
      end else if (run_req && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
      done <= fire;
      error <= fire && inject_err;
    end
  end
endmodule // stc_far_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the self-test and reset control
// Assumes: short filter and stretch counts set through parameters
// Notes: reads queue their expected byte, a monitor compares the answer
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned FILT = 20;
  localparam int unsigned STR = 16;
  localparam logic [15:0] A_CMD = stc_pkg::STC_ADDR_CMD;
  localparam logic [15:0] A_SCR = stc_pkg::STC_ADDR_SCRATCH;
  logic I_CLK_SYS, I_RESET, I_WR, I_RD, I_SLOW_OSC, I_SYSTEM_CLOCK_PRESENT, I_NORMAL_MODE, I_LVD;
  logic I_WDT_RESET, I_ECC_RESET, O_BIST_MEM, O_BIST_LOGIC, O_BIST_PIN_MON, O_BIST_ABORT;
  logic O_CPU_STALL, O_EXT_RESET_N_OUT, O_EXT_RESET_N_OE, O_SW_RESET, O_HW_RESET;
  logic done, err, pin, pin_low, inj, rd_d, hw_seen, pf, pfin, t;
  logic [15:0] I_ADDR;
  logic [7:0] I_WDATA, O_RDATA, dly, sv, d;
  logic [3:0] O_BIST_MODE, m;
  logic [7:0] exp_q[$];
  logic [6:0] modes [6] = '{7'h0C, 7'h22, 7'h4D, 7'h40, 7'h00, 7'h10};
  int n_mismatch, compares, seed, n;
  stc_self_test_reset #(.PIN_FILTER_CYC(FILT), .STRETCH_CYC(STR)) dut (
    .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_BIST_DONE(done), .I_BIST_ERROR(err),
    .O_BIST_MEM(O_BIST_MEM), .O_BIST_LOGIC(O_BIST_LOGIC), .O_BIST_PIN_MON(O_BIST_PIN_MON),
    .O_BIST_ABORT(O_BIST_ABORT), .O_BIST_MODE(O_BIST_MODE), .O_CPU_STALL(O_CPU_STALL),
    .I_SLOW_OSC(I_SLOW_OSC), .I_SYSTEM_CLOCK_PRESENT(I_SYSTEM_CLOCK_PRESENT),
    .I_NORMAL_MODE(I_NORMAL_MODE), .I_LVD(I_LVD), .I_WDT_RESET(I_WDT_RESET),
    .I_ECC_RESET(I_ECC_RESET), .I_EXT_RESET_N_IN(pin), .O_EXT_RESET_N_OUT(O_EXT_RESET_N_OUT),
    .O_EXT_RESET_N_OE(O_EXT_RESET_N_OE), .O_SW_RESET(O_SW_RESET), .O_HW_RESET(O_HW_RESET));
  stc_far_model far (.clk(I_CLK_SYS), .rst(I_RESET), .run_req(O_BIST_MEM || O_BIST_LOGIC),
    .delay(dly), .inject_err(inj), .pin_pull_low(pin_low), .pin_oe(O_EXT_RESET_N_OE),
    .pin_out(O_EXT_RESET_N_OUT), .done(done), .error(err), .pin_level(pin));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] dat);
    @(posedge I_CLK_SYS);
    I_ADDR <= a;
    I_WDATA <= dat;
    I_WR <= 1'b1;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge I_CLK_SYS);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0;
  endtask
  task automatic wrrd(input logic [15:0] a, input logic [7:0] dat);
    exp_q.push_back(dat);
    @(posedge I_CLK_SYS);
    I_ADDR <= a;
    I_WDATA <= dat;
    I_WR <= 1'b1;
    @(posedge I_CLK_SYS);
    I_WR <= 1'b0;
    I_RD <= 1'b1;
    @(posedge I_CLK_SYS);
    I_RD <= 1'b0;
  endtask
  task automatic wait_hw(output int k);
    k = 0;
    while (O_HW_RESET !== 1'b0 && k < 400) begin
      @(posedge I_CLK_SYS);
      #1;
      k++;
    end
  endtask
  task automatic watch(input int cyc);
    hw_seen = 1'b0;
    repeat (cyc) begin
      @(posedge I_CLK_SYS);
      hw_seen = hw_seen | O_HW_RESET;
    end
  endtask
  task automatic run_test(input logic [7:0] wd, input logic [7:0] dl, input logic e,
    input logic [6:0] outs, output int k);
    dly <= dl;
    inj <= e;
    wr(A_CMD, wd);
    #1;
    check({1'b0, O_BIST_MODE, O_BIST_MEM, O_BIST_LOGIC, O_BIST_PIN_MON}, {1'b0, outs});
    check(O_CPU_STALL, 1'b1);
    k = 0;
    while (O_CPU_STALL === 1'b1 && k < 300) begin
      @(posedge I_CLK_SYS);
      #1;
      k++;
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    I_CLK_SYS = 1'b0;
    forever #2.5 I_CLK_SYS = ~I_CLK_SYS;
  end
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop();
  end
  always @(posedge I_CLK_SYS) begin
    if (rd_d && exp_q.size() > 0) check(O_RDATA, exp_q.pop_front());
    rd_d <= I_RD;
  end
  initial begin
    forever begin
      repeat (8) @(posedge I_CLK_SYS);
      I_SLOW_OSC <= ~I_SLOW_OSC;
    end
  end
  initial begin
    {I_RESET, I_WR, I_RD, I_SLOW_OSC, I_SYSTEM_CLOCK_PRESENT, I_NORMAL_MODE} = 6'b100011;
    {I_LVD, I_WDT_RESET, I_ECC_RESET, pin_low, inj, rd_d, pf, pfin} = 8'h00;
    {I_ADDR, I_WDATA, dly} = 32'h0000_0001;
    seed = 32'h7dfd;
    repeat (2) @(posedge I_CLK_SYS);
    I_RESET <= 1'b0;
    wait_hw(n);
    check(n >= STR && n < 400, 1'b1);
    rd(A_CMD, 8'h00);
    rd(A_SCR, stc_pkg::STC_SCRATCH_RST);
    sv = 8'($random(seed));
    wrrd(A_SCR, sv);
    rd(16'hA015, 8'h00);
    $display("test registers finished");
    for (int i = 0; i < 6; i++) begin
      m = modes[i][6:3];
      t = modes[i][2:0] != 3'b000;
      d = 8'(($random(seed) & 31) + 1);
      wr(A_CMD, {m, 4'hF});
      rd(A_CMD, {m, 2'b00, pf, pfin});
      run_test({m, stc_pkg::STC_CMD_RUN}, d, i[0], modes[i], n);
      check(8'(n), t ? d + 8'h02 : 8'h01);
      pf = t & i[0];
      pfin = 1'b1;
      rd(A_CMD, {m, 2'b00, pf, 1'b1});
    end
    wr(A_CMD, 8'h10);
    rd(A_CMD, 8'h10);
    dly <= 8'h3C;
    wr(A_CMD, 8'h15);
    repeat (5) @(posedge I_CLK_SYS);
    wr(A_CMD, 8'h83);
    #1;
    check({O_BIST_ABORT, O_CPU_STALL, O_BIST_MODE}, 6'h21);
    $display("test self-test finished");
    wr(A_CMD, 8'h4F);
    run_test(8'h4A, 8'h03, 1'b0, 7'h22, n);
    check(O_SW_RESET, 1'b1);
    check(8'(n), 8'h05);
    @(posedge I_CLK_SYS);
    #1;
    check(O_SW_RESET, 1'b0);
    for (int k = 0; k < 2; k++) begin
      @(posedge I_CLK_SYS);
      I_WDT_RESET <= (k == 0);
      I_ECC_RESET <= (k == 1);
      @(posedge I_CLK_SYS);
      I_WDT_RESET <= 1'b0;
      I_ECC_RESET <= 1'b0;
      #1;
      check({O_SW_RESET, O_HW_RESET}, 2'b10);
    end
    rd(A_CMD, 8'h41);
    rd(A_SCR, sv);
    $display("test software reset finished");
    pin_low <= 1'b1;
    repeat (FILT - 6) @(posedge I_CLK_SYS);
    pin_low <= 1'b0;
    watch(40);
    check(hw_seen, 1'b0);
    pin_low <= 1'b1;
    repeat (FILT + 10) @(posedge I_CLK_SYS);
    #1;
    check({O_HW_RESET, O_EXT_RESET_N_OE, O_EXT_RESET_N_OUT, pin}, 4'b1100);
    @(posedge I_CLK_SYS);
    pin_low <= 1'b0;
    wait_hw(n);
    check(n >= STR && n < 400, 1'b1);
    rd(A_CMD, 8'h00);
    rd(A_SCR, sv);
    I_NORMAL_MODE <= 1'b0;
    I_SYSTEM_CLOCK_PRESENT <= 1'b0;
    watch(150);
    check(hw_seen, 1'b0);
    I_NORMAL_MODE <= 1'b1;
    watch(20);
    check(hw_seen, 1'b0);
    watch(180);
    check(hw_seen, 1'b1);
    I_SYSTEM_CLOCK_PRESENT <= 1'b1;
    wait_hw(n);
    check(n >= STR && n < 400, 1'b1);
    I_LVD <= 1'b1;
    repeat (10) @(posedge I_CLK_SYS);
    #1;
    check(O_HW_RESET, 1'b1);
    @(posedge I_CLK_SYS);
    I_LVD <= 1'b0;
    wait_hw(n);
    check(O_HW_RESET, 1'b0);
    $display("test hardware reset finished");
    repeat (4) @(posedge I_CLK_SYS);
    check(8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule // tb_top
